// >>> inc/cpc_pkg.sv
// Shared constants, types and register map of the carrier phase control block
package cpc_pkg;

    localparam int N_OSC = 4;
    localparam int PH_W = 16;
    localparam int ENV_W = 16;
    localparam int SIN_W = 8;
    localparam int OUT_W = 18;
    localparam int ROM_AW = 6;
    localparam int AV_AW = 8;

    localparam logic [AV_AW-1:0] REG_CTRL = 8'h00;
    localparam logic [AV_AW-1:0] REG_OSC_SEL = 8'h04;
    localparam logic [AV_AW-1:0] REG_STATUS = 8'h08;
    localparam logic [3:0] REG_FREQ_PAGE = 4'h1;
    localparam logic [3:0] REG_PHASE_PAGE = 4'h2;
    localparam logic [3:0] REG_ACC_PAGE = 4'h3;

    localparam int CTRL_OWN_BIT = 0;
    localparam int CTRL_MOD_LSB = 1;
    localparam int CTRL_GEN_N_LSB = 3;
    localparam int CTRL_GEN_M_LSB = 5;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_PEND_LSB = 1;
    localparam int STAT_OWN_BIT = 5;

    localparam logic OWN_RST = 1'b1;
    localparam logic [1:0] MOD_RST = 2'h0;
    localparam logic [1:0] GEN_N_RST = 2'h0;
    localparam logic [1:0] GEN_M_RST = 2'h1;
    localparam logic [7:0] OSC_SEL_RST = 8'he4;
    localparam logic [PH_W-1:0] FREQ_RST = 16'h0000;

    localparam logic [1:0] MOD_OFF = 2'h0;
    localparam logic [1:0] MOD_PAIR = 2'h1;
    localparam logic [1:0] MOD_ADV = 2'h2;

    localparam int CLK_PERIOD_NS = 20;
    localparam int SYNC_TIME_NS = 2000;
    localparam int SYNC_CYCLES = (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_CW = 7;
    localparam logic [SYNC_CW-1:0] SYNC_LOAD = SYNC_CW'(SYNC_CYCLES - 1);

    typedef enum logic [2:0] {
        OP_LOAD = 3'b001,
        OP_ADD = 3'b010,
        OP_CLEAR = 3'b100
    } cpc_op_e;

    typedef enum logic [1:0] {
        SYNC_IDLE = 2'b01,
        SYNC_BUSY = 2'b10
    } cpc_sync_e;

    typedef struct packed {
        logic valid;
        cpc_op_e op;
        logic [1:0] gen;
        logic [PH_W-1:0] value;
        logic has_mask;
        logic [N_OSC-1:0] mask;
    } cpc_instr_s;

    typedef struct packed {
        logic valid;
        logic [ENV_W-1:0] ch1;
        logic [ENV_W-1:0] ch2;
    } cpc_env_s;

    typedef struct packed {
        logic [OUT_W-1:0] w1;
        logic [OUT_W-1:0] w2;
    } cpc_wave_s;

endpackage

// >>> rtl/cpc_sine_rom.sv
// One-period sine lookup built from a quarter-wave table, registered output
`timescale 1ns/1ps
module cpc_sine_rom (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [cpc_pkg::ROM_AW-1:0] idx,
    output logic signed [cpc_pkg::SIN_W-1:0] sine_q
);
    import cpc_pkg::*;

    localparam logic [6:0] QTAB [16] = '{
        7'h06, 7'h13, 7'h1f, 7'h2b, 7'h36, 7'h41, 7'h4c, 7'h55,
        7'h5e, 7'h66, 7'h6d, 7'h73, 7'h78, 7'h7b, 7'h7e, 7'h7f
    };

    wire logic [3:0] q_idx = idx[4] ? ~idx[3:0] : idx[3:0];
    wire logic [SIN_W-1:0] mag = {1'b0, QTAB[q_idx]};
    wire logic [SIN_W-1:0] val = idx[5] ? (~mag + 8'h01) : mag;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sine_q <= 8'sh00;
        end else begin
            sine_q <= signed'(val);
        end
    end
endmodule

// >>> rtl/cpc_carrier_phase_control.sv
// Carrier phase control: owned oscillators, sine generators, modulation and register slave
//
// Our own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
// Functional notes
// - Load or add carrier phase in real time
// - Oscillator phases can be reset at sequence start
// - Replica frequency update is slow, not real-time
// - Fast reset only in ownership mode; disables sync
// - Core uses only its own four oscillators
// - Without option, ownership fixed and not configurable
// - Reset without operand clears all owned oscillators
// - Mask operand clears only selected owned oscillators
// - Increment applied when preceding playback ends
// - Increment before first playback waits for it
// - Multi-carrier: four lanes, each times own oscillator
// - Lanes update quarter rate, products full rate
// - Advanced mode: each lane has selectable oscillator
// - Every oscillator accumulates phase independently
// - Generator pair: N on output one, M two
// - Phase accumulator plus offset through sine table
module cpc_carrier_phase_control #(
    parameter bit MF_OPTION = 1'b1
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [cpc_pkg::AV_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire cpc_pkg::cpc_instr_s seq_instr,
    input wire logic play_end,
    input wire cpc_pkg::cpc_env_s env_in,
    output cpc_pkg::cpc_wave_s wave_out
);
    import cpc_pkg::*;

    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [ENV_W-1:0] mul_scale(input logic [ENV_W-1:0] e, input logic [SIN_W-1:0] s);
        logic signed [ENV_W+SIN_W-1:0] p;
        p = signed'(e) * signed'(s);
        return p[ENV_W+SIN_W-2 -: ENV_W];
    endfunction

    function automatic logic [OUT_W-1:0] sext(input logic [ENV_W-1:0] v);
        return {{(OUT_W-ENV_W){v[ENV_W-1]}}, v};
    endfunction

    logic wait_r;
    logic [31:0] rdata_r;
    logic own_mode_r;
    logic [1:0] mod_r;
    logic [1:0] gen_n_r;
    logic [1:0] gen_m_r;
    logic [7:0] osc_sel_r;
    logic [PH_W-1:0] freq_r [N_OSC];
    logic [PH_W-1:0] stage_r [N_OSC];
    cpc_sync_e sync_state_r;
    cpc_sync_e sync_state_nxt;
    logic [SYNC_CW-1:0] sync_cnt_r;
    logic [SYNC_CW-1:0] sync_cnt_nxt;
    logic [PH_W-1:0] osc_acc_r [N_OSC];
    logic [PH_W-1:0] gen_phase_r [N_OSC];
    logic [PH_W-1:0] gen_phase_nxt [N_OSC];
    logic [PH_W-1:0] pend_r [N_OSC];
    logic [PH_W-1:0] pend_nxt [N_OSC];
    logic [N_OSC-1:0] pend_flag_r;
    logic [N_OSC-1:0] pend_flag_nxt;
    logic [ENV_W-1:0] lane_r [N_OSC];
    logic [ENV_W-1:0] env1_r;
    logic [ENV_W-1:0] env2_r;
    logic [1:0] lane_cnt_r;
    logic [SIN_W-1:0] sine_q [N_OSC];
    logic [PH_W-1:0] phase_sum [N_OSC];
    logic [ENV_W-1:0] lane_prod [N_OSC];

    // Register slave: waitrequest drops for one cycle per access
    wire logic wr_en = avs_write && !wait_r;
    wire logic rd_take = avs_read && wait_r;
    wire logic [3:0] page = avs_address[7:4];
    wire logic [1:0] widx = avs_address[3:2];
    wire logic ctrl_hit = (avs_address == REG_CTRL);
    wire logic sel_hit = (avs_address == REG_OSC_SEL);
    wire logic stat_hit = (avs_address == REG_STATUS);
    wire logic freq_hit = (page == REG_FREQ_PAGE) && (avs_address[1:0] == 2'h0);
    wire logic phase_hit = (page == REG_PHASE_PAGE) && (avs_address[1:0] == 2'h0);
    wire logic acc_hit = (page == REG_ACC_PAGE) && (avs_address[1:0] == 2'h0);
    wire logic freq_wr = wr_en && freq_hit;

    wire logic [31:0] ctrl_val = {25'h0, gen_m_r, gen_n_r, mod_r, own_mode_r};
    wire logic [31:0] stat_val = {26'h0, own_mode_r, pend_flag_r, sync_state_r == SYNC_BUSY};
    wire logic [31:0] ctrl_w = be_merge(ctrl_val, avs_writedata, avs_byteenable);
    wire logic [31:0] sel_w = be_merge({24'h0, osc_sel_r}, avs_writedata, avs_byteenable);
    wire logic [31:0] freq_w = be_merge({16'h0, stage_r[widx]}, avs_writedata, avs_byteenable);
    wire logic [31:0] rd_mux = ctrl_hit ? ctrl_val :
                               sel_hit ? {24'h0, osc_sel_r} :
                               stat_hit ? stat_val :
                               freq_hit ? {16'h0, freq_r[widx]} :
                               phase_hit ? {16'h0, gen_phase_r[widx]} :
                               acc_hit ? {16'h0, osc_acc_r[widx]} : 32'h0;
    // Without the option the ownership bit stays set
    wire logic own_w = MF_OPTION ? ctrl_w[CTRL_OWN_BIT] : 1'b1;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_r <= 1'b1;
            rdata_r <= 32'h0;
        end else begin
            wait_r <= !((avs_read || avs_write) && wait_r);
            if (rd_take) begin
                rdata_r <= rd_mux;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            own_mode_r <= OWN_RST;
            mod_r <= MOD_RST;
            gen_n_r <= GEN_N_RST;
            gen_m_r <= GEN_M_RST;
            osc_sel_r <= OSC_SEL_RST;
        end else if (wr_en && ctrl_hit) begin
            own_mode_r <= own_w;
            mod_r <= ctrl_w[CTRL_MOD_LSB +: 2];
            gen_n_r <= ctrl_w[CTRL_GEN_N_LSB +: 2];
            gen_m_r <= ctrl_w[CTRL_GEN_M_LSB +: 2];
        end else if (wr_en && sel_hit) begin
            osc_sel_r <= sel_w[7:0];
        end
    end

    // Replica synchronisation: staged frequencies land after a slow delay
    wire logic sync_done = (sync_state_r == SYNC_BUSY) && (own_mode_r || sync_cnt_r == '0);

    always_comb begin
        sync_state_nxt = sync_state_r;
        sync_cnt_nxt = sync_cnt_r;
        unique case (sync_state_r)
            SYNC_IDLE: begin
                sync_cnt_nxt = sync_cnt_r;
            end
            SYNC_BUSY: begin
                if (sync_done) begin
                    sync_state_nxt = SYNC_IDLE;
                end else begin
                    sync_cnt_nxt = sync_cnt_r - 1'b1;
                end
            end
        endcase
        if (freq_wr && !own_mode_r) begin
            sync_state_nxt = SYNC_BUSY;
            sync_cnt_nxt = SYNC_LOAD;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_state_r <= SYNC_IDLE;
            sync_cnt_r <= '0;
        end else begin
            sync_state_r <= sync_state_nxt;
            sync_cnt_r <= sync_cnt_nxt;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int k = 0; k < N_OSC; k++) begin
                freq_r[k] <= FREQ_RST;
                stage_r[k] <= FREQ_RST;
            end
        end else begin
            for (int k = 0; k < N_OSC; k++) begin
                if (freq_wr && widx == 2'(k)) begin
                    stage_r[k] <= freq_w[PH_W-1:0];
                end
                if (freq_wr && own_mode_r && widx == 2'(k)) begin
                    freq_r[k] <= freq_w[PH_W-1:0];
                end else if (sync_done) begin
                    freq_r[k] <= stage_r[k];
                end
            end
        end
    end

    // Sequencer instruction decode
    wire logic is_load = seq_instr.valid && seq_instr.op == OP_LOAD;
    wire logic is_add = seq_instr.valid && seq_instr.op == OP_ADD;
    // Oscillator clear is ignored outside ownership mode
    wire logic is_clear = seq_instr.valid && seq_instr.op == OP_CLEAR && own_mode_r;
    wire logic [N_OSC-1:0] clr_mask = !is_clear ? 4'h0 :
                                      seq_instr.has_mask ? seq_instr.mask : 4'hf;

    // Only the four owned oscillators exist here, so no other can be touched
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int k = 0; k < N_OSC; k++) begin
                osc_acc_r[k] <= '0;
            end
        end else begin
            for (int k = 0; k < N_OSC; k++) begin
                osc_acc_r[k] <= clr_mask[k] ? '0 : osc_acc_r[k] + freq_r[k];
            end
        end
    end

    // Loads act at once; increments wait in a pending sum until playback ends
    always_comb begin
        for (int k = 0; k < N_OSC; k++) begin
            gen_phase_nxt[k] = (is_load && seq_instr.gen == 2'(k)) ? seq_instr.value : gen_phase_r[k];
            pend_nxt[k] = pend_r[k] + ((is_add && seq_instr.gen == 2'(k)) ? seq_instr.value : '0);
            pend_flag_nxt[k] = pend_flag_r[k] || (is_add && seq_instr.gen == 2'(k));
            if (play_end) begin
                gen_phase_nxt[k] = gen_phase_nxt[k] + pend_nxt[k];
                pend_nxt[k] = '0;
                pend_flag_nxt[k] = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_flag_r <= '0;
            for (int k = 0; k < N_OSC; k++) begin
                gen_phase_r[k] <= '0;
                pend_r[k] <= '0;
            end
        end else begin
            pend_flag_r <= pend_flag_nxt;
            for (int k = 0; k < N_OSC; k++) begin
                gen_phase_r[k] <= gen_phase_nxt[k];
                pend_r[k] <= pend_nxt[k];
            end
        end
    end

    // Sine generators: selected owned oscillator plus own offset
    for (genvar g = 0; g < N_OSC; g++) begin : gen_sine
        assign phase_sum[g] = osc_acc_r[osc_sel_r[2*g +: 2]] + gen_phase_r[g];
        assign lane_prod[g] = mul_scale(lane_r[g], sine_q[g]);
        cpc_sine_rom u_rom (
            .sys_clk(sys_clk),
            .rst_b(rst_b),
            .idx(phase_sum[g][PH_W-1 -: ROM_AW]),
            .sine_q(sine_q[g])
        );
    end

    // Envelope capture and interleave into lanes
    wire logic adv_mode = (mod_r == MOD_ADV);
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            env1_r <= '0;
            env2_r <= '0;
            lane_cnt_r <= 2'h0;
            for (int k = 0; k < N_OSC; k++) begin
                lane_r[k] <= '0;
            end
        end else if (env_in.valid) begin
            env1_r <= env_in.ch1;
            env2_r <= env_in.ch2;
            if (adv_mode) begin
                lane_r[lane_cnt_r] <= env_in.ch1;
                lane_cnt_r <= lane_cnt_r + 2'h1;
            end else begin
                lane_cnt_r <= 2'h0;
            end
        end
    end

    wire logic [OUT_W-1:0] adv_sum = sext(lane_prod[0]) + sext(lane_prod[1])
                                   + sext(lane_prod[2]) + sext(lane_prod[3]);
    wire logic [OUT_W-1:0] pair_w1 = sext(mul_scale(env1_r, sine_q[gen_n_r]));
    wire logic [OUT_W-1:0] pair_w2 = sext(mul_scale(env2_r, sine_q[gen_m_r]));
    wire logic [OUT_W-1:0] w1_sel = adv_mode ? adv_sum : (mod_r == MOD_PAIR) ? pair_w1 : sext(env1_r);
    wire logic [OUT_W-1:0] w2_sel = (mod_r == MOD_PAIR || adv_mode) ? pair_w2 : sext(env2_r);

    // Products refresh every clock, whatever the lane update rate
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wave_out <= '0;
        end else begin
            wave_out.w1 <= w1_sel;
            wave_out.w2 <= w2_sel;
        end
    end

    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;

    sequence sync_start_s;
        freq_wr && !own_mode_r;
    endsequence

    sequence own_hold_s;
        (!own_mode_r) [*8];
    endsequence

    sync_slow_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        sync_start_s ##1 own_hold_s |-> sync_state_r == SYNC_BUSY)
        else $error("replica sync finished too early");

    sync_off_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        own_mode_r && !freq_wr |=> sync_state_r == SYNC_IDLE)
        else $error("sync path active in ownership mode");

    clr_own_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        seq_instr.valid && seq_instr.op == OP_CLEAR && !own_mode_r
        |=> osc_acc_r[0] == $past(osc_acc_r[0]) + $past(freq_r[0]))
        else $error("oscillator cleared outside ownership mode");

    fixed_own_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !MF_OPTION |-> own_mode_r)
        else $error("ownership left without option");

    clr_all_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        is_clear && !seq_instr.has_mask |=> osc_acc_r[0] == '0 && osc_acc_r[3] == '0)
        else $error("unmasked clear missed an oscillator");

    clr_mask_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        is_clear && seq_instr.has_mask && !seq_instr.mask[1]
        |=> osc_acc_r[1] == $past(osc_acc_r[1]) + $past(freq_r[1]))
        else $error("unselected oscillator was cleared");

    load_phase_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        is_load && seq_instr.gen == 2'h0 && !play_end |=> gen_phase_r[0] == $past(seq_instr.value))
        else $error("phase load not applied");

    inc_defer_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        is_add && seq_instr.gen == 2'h1 && !play_end ##1 (!play_end && !is_load) [*2]
        |-> $stable(gen_phase_r[1]) && pend_flag_r[1])
        else $error("increment applied before playback end");

    inc_apply_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        play_end && !seq_instr.valid |=> gen_phase_r[1] == $past(gen_phase_r[1]) + $past(pend_r[1])
        && pend_r[1] == '0)
        else $error("pending increment not applied at playback end");

    acc_run_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !is_clear [*2] |-> osc_acc_r[2] == $past(osc_acc_r[2]) + $past(freq_r[2]))
        else $error("oscillator did not advance by its frequency");

    lane_rr_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        adv_mode && env_in.valid |=> lane_cnt_r == $past(lane_cnt_r) + 2'h1
        && lane_r[$past(lane_cnt_r)] == $past(env_in.ch1))
        else $error("interleave lane order broken");

    adv_out_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        adv_mode |=> wave_out.w1 == $past(adv_sum))
        else $error("multi-carrier sum not on output");
endmodule

// >>> tb/cpc_seq_model.sv
// Sequencer stand-in that issues phase instructions and playback-end pulses
`timescale 1ns/1ps
module cpc_seq_model (
    input wire logic sys_clk,
    output cpc_pkg::cpc_instr_s seq_instr,
    output logic play_end
);
    import cpc_pkg::*;

    initial begin
        seq_instr = '0;
        play_end = 1'b0;
    end

    // One-cycle pulse; released fields are inverted so stale values never pass for a held one
    task automatic issue(input cpc_op_e op, input logic [1:0] gen, input logic [PH_W-1:0] value,
                         input logic has_mask, input logic [N_OSC-1:0] mask);
        cpc_instr_s s;
        s = '{valid: 1'b1, op: op, gen: gen, value: value, has_mask: has_mask, mask: mask};
        @(posedge sys_clk);
        seq_instr <= s;
        @(posedge sys_clk);
        s = ~s;
        s.valid = 1'b0;
        seq_instr <= s;
    endtask

    // Marks the end of one waveform playback
    task automatic play();
        @(posedge sys_clk);
        play_end <= 1'b1;
        @(posedge sys_clk);
        play_end <= 1'b0;
    endtask
endmodule

// >>> tb/cpc_carrier_phase_control_test.sv
// Self-checking bench for the carrier phase control block
`timescale 1ns/1ps
module cpc_carrier_phase_control_test;
    import cpc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [AV_AW-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    cpc_instr_s seq_instr;
    logic play_end;
    cpc_env_s env_in = '0;
    cpc_wave_s wave_out;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    logic [15:0] v;
    logic [15:0] a;
    logic [15:0] b;
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;
    localparam logic [32:0] NZ = 33'h1_0000_0000;

    always #10 sys_clk = ~sys_clk;

    cpc_carrier_phase_control #(.MF_OPTION(1'b1)) u_cpc_carrier_phase_control (
        .sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .seq_instr(seq_instr),
        .play_end(play_end), .env_in(env_in), .wave_out(wave_out)
    );
    cpc_seq_model u_cpc_seq_model (.sys_clk(sys_clk), .seq_instr(seq_instr), .play_end(play_end));

    task automatic finish_test();
        $display("mismatches %0d, checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Holds the request until waitrequest is sampled low, then releases it
    task automatic bus(input logic rd_n_wr, input logic [AV_AW-1:0] adr, input logic [31:0] d);
        @(posedge sys_clk);
        avs_read <= rd_n_wr;
        avs_write <= !rd_n_wr;
        avs_address <= adr;
        avs_writedata <= d;
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rd(input logic [AV_AW-1:0] adr, input logic [32:0] exp);
        exp_q.push_back(exp);
        bus(1'b1, adr, 32'h0);
    endtask

    task automatic wr(input logic [AV_AW-1:0] adr, input logic [31:0] d);
        bus(1'b0, adr, d);
    endtask

    function automatic logic [AV_AW-1:0] pg(input logic [3:0] page, input int k);
        return {page, k[1:0], 2'b00};
    endfunction

    // Read data stand in the cycle waitrequest is low; taken at the edge that ends it
    always @(posedge sys_clk) begin
        if (avs_read && avs_waitrequest === 1'b0) begin
            if (exp_q.size() == 0) begin
                check(32'h1, 32'h0, "read with no expectation");
            end else begin
                e = exp_q.pop_front();
                if (e[32]) begin
                    check({31'h0, avs_readdata != 32'h0}, 32'h1, "read nonzero");
                end else begin
                    check(avs_readdata, e[31:0], "read data");
                end
            end
        end
    end

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            finish_test();
        end
    end

    initial begin
        void'($urandom(52));
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(REG_CTRL, 33'h21);
        rd(REG_OSC_SEL, 33'he4);
        rd(REG_STATUS, 33'h20);
        wr(REG_STATUS, 32'hffffffff);
        rd(REG_STATUS, 33'h20);
        rd(8'h40, 33'h0);
        v = 16'($urandom);
        u_cpc_seq_model.issue(OP_LOAD, 2'h0, v, 1'b0, 4'h0);
        rd(pg(REG_PHASE_PAGE, 0), {17'h0, v});
        u_cpc_seq_model.issue(OP_LOAD, 2'h1, 16'hf000, 1'b0, 4'h0);
        u_cpc_seq_model.issue(OP_ADD, 2'h1, 16'h2000, 1'b0, 4'h0);
        u_cpc_seq_model.issue(OP_ADD, 2'h1, 16'h2aaa, 1'b0, 4'h0);
        rd(pg(REG_PHASE_PAGE, 1), 33'hf000);
        rd(REG_STATUS, 33'h24);
        u_cpc_seq_model.play();
        rd(pg(REG_PHASE_PAGE, 1), 33'h3aaa);
        rd(REG_STATUS, 33'h20);
        for (int k = 0; k < 4; k++) wr(pg(REG_FREQ_PAGE, k), 32'h100 * (k + 1));
        repeat (20) @(posedge sys_clk);
        for (int k = 0; k < 4; k++) wr(pg(REG_FREQ_PAGE, k), 32'h0);
        u_cpc_seq_model.issue(OP_CLEAR, 2'h0, 16'h0, 1'b1, 4'b0101);
        for (int k = 0; k < 4; k++) rd(pg(REG_ACC_PAGE, k), k[0] ? NZ : 33'h0);
        wr(REG_CTRL, 32'h20);
        u_cpc_seq_model.issue(OP_CLEAR, 2'h0, 16'h0, 1'b0, 4'h0);
        rd(pg(REG_ACC_PAGE, 3), NZ);
        rd(REG_STATUS, 33'h0);
        wr(pg(REG_FREQ_PAGE, 0), 32'h1);
        rd(REG_STATUS, 33'h1);
        rd(pg(REG_FREQ_PAGE, 0), 33'h0);
        repeat (110) @(posedge sys_clk);
        rd(pg(REG_FREQ_PAGE, 0), 33'h1);
        wr(REG_CTRL, 32'h21);
        wr(pg(REG_FREQ_PAGE, 0), 32'h0);
        u_cpc_seq_model.issue(OP_CLEAR, 2'h0, 16'h0, 1'b0, 4'h0);
        for (int k = 0; k < 4; k++) rd(pg(REG_ACC_PAGE, k), 33'h0);
        v = 16'($urandom);
        a = {v[15], ~v[15], v[13:0]};
        v = 16'($urandom);
        b = {v[15], ~v[15], v[13:0]};
        @(posedge sys_clk);
        env_in <= '{valid: 1'b1, ch1: a, ch2: b};
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        check({14'h0, wave_out.w1}, {14'h0, {2{a[15]}}, a}, "unmodulated w1");
        check({14'h0, wave_out.w2}, {14'h0, {2{b[15]}}, b}, "unmodulated w2");
        u_cpc_seq_model.issue(OP_LOAD, 2'h0, 16'h4000, 1'b0, 4'h0);
        u_cpc_seq_model.issue(OP_LOAD, 2'h1, 16'hc000, 1'b0, 4'h0);
        wr(REG_CTRL, 32'h23);
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        check({31'h0, wave_out.w1[OUT_W-1]}, {31'h0, a[15]}, "pair w1 sign");
        check({31'h0, wave_out.w2[OUT_W-1]}, {31'h0, ~b[15]}, "pair w2 sign");
        // Advanced mode: one sample per lane, only lane 0 carries the envelope
        @(posedge sys_clk);
        env_in <= '0;
        wr(REG_CTRL, 32'h25);
        for (int k = 0; k < 4; k++) begin
            @(posedge sys_clk);
            env_in <= '{valid: 1'b1, ch1: (k == 0) ? a : 16'h0, ch2: b};
        end
        @(posedge sys_clk);
        env_in <= '0;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        check({31'h0, wave_out.w1[OUT_W-1]}, {31'h0, a[15]}, "lane 0 carrier sign");
        check({31'h0, |wave_out.w1[OUT_W-1:12] && !(&wave_out.w1[OUT_W-1:12])}, 32'h1, "lane 0 scale");
        repeat (4) @(posedge sys_clk);
        finish_test();
    end
endmodule
